/* File: rtl/rct_top.sv */
// Purpose: control, charge selection and oscillator-stop flag registers with the calibration engine
// Assumes: register strobes come from the serial front end on core_clk; osc_clk is the oscillator
// Notes:   only bit 7 of the seconds location is held here; other clock locations read 0
//
// How it works
// R1 - with frequency test off the test pin follows the output-level bit
// R2 - output-level bit resets to 1 so the test pin starts high
// R3 - frequency test on toggles the pin at 512 Hz; bit resets to 0
// R4 - sign 1 means positive trim, 0 negative; resets to 0
// R5 - five-bit trim magnitude in control bits 4..0, any value 0..31
// R6 - trim magnitude resets to 0
// R7 - charger enabled only when key field equals 1010
// R8 - charge selection register resets to all zeros, charger off
// R9 - diode field 01 none, 10 one diode, 00 or 11 off
// R10 - resistor field 01 small, 10 middle, 11 large, 00 off
// R11 - halt flag sets on the running-to-stopped edge of the oscillator
// R12 - halt flag set at power-up and when the oscillator is disabled
// R13 - halt flag clears only by writing 0; writing 1 leaves it
// R14 - status bits 6..0 read 0 and ignore writes
// R15 - trim adds or removes counts at the divide-by-256 stage
// R16 - 64-minute cycle, one trim second per minute in the first 62
// R17 - negative trim blanks 128 cycles, positive inserts 256
// R18 - magnitude N trims the first 2N minutes of the cycle
// R19 - trim never changes the 512 Hz test frequency
// R20 - any control write resets the divider chain unless the oscillator is disabled
// R21 - seconds bit 7 set stops the oscillator; resets to 0
// R22 - pointer wraps to 00h after 09h
// R23 - calibration position comes from the block's own divided counters
`timescale 1ns/1ps
`include "rct_map.svh"
module rct_top
   import rct_pkg::*;
#(
   parameter int STOP_CYCLES = `RCT_STOP_WAIT_NS / `RCT_CORE_PERIOD_NS
)(
   // clocks and reset
   input  wire logic          core_clk,
   input  wire logic          nrst,
   input  wire logic          osc_clk,
   // register access from the serial front end
   input  wire logic          reg_ptr_wr,
   input  wire logic          reg_data_wr,
   input  wire logic          reg_data_rd,
   input  wire rct_byte_type  reg_wdata,
   output rct_byte_type       reg_rdata,
   output rct_addr_type       reg_ptr,
   // pins and analog controls
   output logic               pin_test_drive,
   output logic               charge_enable,
   output logic               charge_diode,
   output logic [1:0]         charge_res,
   output logic               osc_running
);
   localparam int W = $clog2(STOP_CYCLES + 1);
   localparam logic [W-1:0] STOP_LIM = W'(STOP_CYCLES);

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   // full charger decode: key, diode and resistor must all be legal
   function automatic logic charge_on(input rct_byte_type r);
      logic key_ok;
      logic diode_ok;
      logic res_ok;
      key_ok   = (r[`RCT_KEY_HI:`RCT_KEY_LO] == `RCT_CHARGE_KEY);                    // [R7]
      diode_ok = (r[`RCT_DIODE_HI:`RCT_DIODE_LO] == `RCT_DIODE_NONE) ||
                 (r[`RCT_DIODE_HI:`RCT_DIODE_LO] == `RCT_DIODE_ONE);                 // [R9]
      res_ok   = (r[`RCT_RES_HI:`RCT_RES_LO] != `RCT_RES_OFF);                       // [R10]
      return key_ok && diode_ok && res_ok;
   endfunction : charge_on

   // pointer advance after a data access
   function automatic rct_addr_type ptr_step(input rct_addr_type p);
      if (p == `RCT_ADDR_LAST || p == `RCT_ADDR_CLOCK_END) return `RCT_ADDR_SECONDS; // [R22]
      return p + 4'h1;
   endfunction : ptr_step

   // ***************************************************************
   // register state
   // ***************************************************************
   logic          osc_disable;
   rct_byte_type  control;
   rct_byte_type  charge;
   logic          osc_halt_flag;
   logic          div_reset_tgl;
   rct_addr_type  ptr;

   // a pointer load in the same cycle as a data strobe wins
   wire data_go   = (reg_data_wr || reg_data_rd) && !reg_ptr_wr;
   wire wr_go     = reg_data_wr && !reg_ptr_wr;
   wire wr_sec    = wr_go && (ptr == `RCT_ADDR_SECONDS);
   wire wr_ctl    = wr_go && (ptr == `RCT_ADDR_CONTROL);
   wire wr_chg    = wr_go && (ptr == `RCT_ADDR_CHARGE);
   wire wr_stat   = wr_go && (ptr == `RCT_ADDR_STATUS);
   wire halt_clr  = wr_stat && !reg_wdata[`RCT_BIT_HALT];          // only a 0 clears [R13]
   wire halt_set;

   // pointer walk
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) ptr <= `RCT_ADDR_SECONDS;
      else if (reg_ptr_wr) ptr <= reg_wdata[`RCT_ADDR_WIDTH-1:0];
      else if (data_go) ptr <= ptr_step(ptr);                      // [R22]
   end

   // writable registers; the divider reset is a toggle so the slow domain never misses it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         osc_disable   <= 1'b0;                                    // [R21]
         control       <= `RCT_CONTROL_RESET;                      // [R2] [R3] [R4] [R6]
         charge        <= `RCT_CHARGE_RESET;                       // [R8]
         div_reset_tgl <= 1'b0;
      end else begin
         if (wr_sec) osc_disable <= reg_wdata[`RCT_BIT_OSC_DISABLE]; // [R21]
         if (wr_ctl) control <= reg_wdata;                         // [R5]
         if (wr_chg) charge <= reg_wdata;
         if (wr_ctl || wr_sec) div_reset_tgl <= !div_reset_tgl;    // [R20]
      end
   end

   // halt flag: power-up value 1, set beats clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) osc_halt_flag <= 1'b1;                            // [R12]
      else if (halt_set) osc_halt_flag <= 1'b1;                    // [R11]
      else if (halt_clr) osc_halt_flag <= 1'b0;                    // [R13]
   end

   // read mux, low status bits hard zero
   rct_byte_type  next_rdata;
   always_comb begin
      next_rdata = `RCT_BYTE_ZERO;
      unique case (ptr)
         `RCT_ADDR_SECONDS: next_rdata[`RCT_BIT_OSC_DISABLE] = osc_disable;
         `RCT_ADDR_CONTROL: next_rdata = control;
         `RCT_ADDR_CHARGE:  next_rdata = charge;
         `RCT_ADDR_STATUS:  next_rdata[`RCT_BIT_HALT] = osc_halt_flag; // [R14]
         default:           next_rdata = `RCT_BYTE_ZERO;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) reg_rdata <= `RCT_BYTE_ZERO;
      else if (reg_data_rd && !reg_ptr_wr) reg_rdata <= next_rdata;
   end

   assign reg_ptr = ptr;

   // ***************************************************************
   // crossing from the oscillator domain
   // ***************************************************************
   rct_cfg_if cfg ();
   assign cfg.div_reset_tgl = div_reset_tgl;
   assign cfg.sign          = control[`RCT_BIT_SIGN];              // [R4]
   assign cfg.osc_disable   = osc_disable;
   assign cfg.magnitude     = control[`RCT_MAG_HI:`RCT_MAG_LO];

   rct_osc_engine u_engine (
      .osc_clk (osc_clk),
      .nrst    (nrst),
      .cfg     (cfg)
   );

   logic [1:0]    beat_sync;
   logic [1:0]    sq_sync;
   logic          beat_last;
   logic [W-1:0]  idle_cnt;
   logic          stopped_last;

   // first stage feeds only the second
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         beat_sync <= 2'b00;
         sq_sync   <= 2'b00;
         beat_last <= 1'b0;
      end else begin
         beat_sync <= {beat_sync[0], cfg.heartbeat};
         sq_sync   <= {sq_sync[0], cfg.square};
         beat_last <= beat_sync[1];
      end
   end

   // activity watchdog; the oscillator counts as stopped after STOP_CYCLES quiet cycles
   wire beat_seen = beat_sync[1] ^ beat_last;
   wire stopped   = (idle_cnt == STOP_LIM) || osc_disable;        // [R12]
   assign halt_set = stopped && !stopped_last;                     // edge, not level [R11]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         idle_cnt     <= '0;
         stopped_last <= 1'b0;
      end else begin
         idle_cnt     <= beat_seen ? '0 : (idle_cnt == STOP_LIM ? idle_cnt : idle_cnt + W'(1));
         stopped_last <= stopped;
      end
   end

   // ***************************************************************
   // pin and charger outputs
   // ***************************************************************
   wire next_pin = control[`RCT_BIT_FREQ_TEST] ? sq_sync[1] : control[`RCT_BIT_OUT_LEVEL]; // [R1] [R3]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_test_drive <= 1'b1;                                   // [R2]
         charge_enable  <= 1'b0;                                   // [R8]
         charge_diode   <= 1'b0;
         charge_res     <= `RCT_RES_OFF;
         osc_running    <= 1'b0;
      end else begin
         pin_test_drive <= next_pin;
         charge_enable  <= charge_on(charge);                      // [R7] [R9] [R10]
         charge_diode   <= charge_on(charge) && (charge[`RCT_DIODE_HI:`RCT_DIODE_LO] == `RCT_DIODE_ONE); // [R9]
         charge_res     <= charge_on(charge) ? charge[`RCT_RES_HI:`RCT_RES_LO] : `RCT_RES_OFF;       // [R10]
         osc_running    <= !stopped;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   pin_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (!control[`RCT_BIT_FREQ_TEST] && $stable(control)) |=> (pin_test_drive == $past(control[`RCT_BIT_OUT_LEVEL]))) // [R1]
      else $error("test pin does not follow the level bit");
   charge_key_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (charge[`RCT_KEY_HI:`RCT_KEY_LO] != `RCT_CHARGE_KEY) |=> !charge_enable) // [R7]
      else $error("charger on without key");
   halt_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(osc_disable) |-> ##[0:1] osc_halt_flag ##1 osc_halt_flag) // [R12]
      else $error("halt flag not set on disable");
   halt_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (halt_clr && !halt_set) |=> !osc_halt_flag) // [R13]
      else $error("write of 0 did not clear halt flag");
   halt_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (osc_halt_flag && !halt_clr) |=> osc_halt_flag) // [R13]
      else $error("halt flag dropped without a 0 write");
   status_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (reg_data_rd && !reg_ptr_wr && ptr == `RCT_ADDR_STATUS) |=> (reg_rdata[6:0] == 7'h00)) // [R14]
      else $error("status low bits not zero");
   ptr_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (data_go && ptr == `RCT_ADDR_LAST) |=> (ptr == `RCT_ADDR_SECONDS)) // [R22]
      else $error("pointer did not wrap after last location");
   ctl_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
      wr_ctl |=> (div_reset_tgl != $past(div_reset_tgl))) // [R20]
      else $error("control write did not request divider reset");
   edge_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (stopped && !stopped_last) |=> osc_halt_flag ##1 osc_halt_flag) // [R11]
      else $error("stop edge did not set halt flag");
endmodule : rct_top

/* File: rtl/rct_map.svh */
// Purpose: offsets, field positions, reset values and timing figures of the trim and flag block
// Assumes: included by bare name from the package and the design files
// Notes:   definitions only
`ifndef RCT_MAP_SVH
`define RCT_MAP_SVH

// ***************************************************************
// register offsets and pointer walk
// ***************************************************************
`define RCT_ADDR_SECONDS     4'h0
`define RCT_ADDR_CLOCK_END   4'h7
`define RCT_ADDR_CONTROL     4'h7
`define RCT_ADDR_CHARGE      4'h8
`define RCT_ADDR_STATUS      4'h9
`define RCT_ADDR_LAST        4'h9
`define RCT_ADDR_WIDTH       4

// ***************************************************************
// field positions
// ***************************************************************
`define RCT_BIT_OSC_DISABLE  7
`define RCT_BIT_OUT_LEVEL    7
`define RCT_BIT_FREQ_TEST    6
`define RCT_BIT_SIGN         5
`define RCT_MAG_HI           4
`define RCT_MAG_LO           0
`define RCT_BIT_HALT         7
`define RCT_KEY_HI           7
`define RCT_KEY_LO           4
`define RCT_DIODE_HI         3
`define RCT_DIODE_LO         2
`define RCT_RES_HI           1
`define RCT_RES_LO           0

// ***************************************************************
// reset values and codes
// ***************************************************************
`define RCT_CONTROL_RESET    8'h80
`define RCT_CHARGE_RESET     8'h00
`define RCT_BYTE_ZERO        8'h00
`define RCT_CHARGE_KEY       4'ha
`define RCT_DIODE_NONE       2'h1
`define RCT_DIODE_ONE        2'h2
`define RCT_RES_OFF          2'h0

// ***************************************************************
// divider chain and calibration figures
// ***************************************************************
`define RCT_LO_LAST          8'hff
`define RCT_SEC_LAST         6'h3b
`define RCT_CAL_MINUTES      6'h3e
`define RCT_BLANK_LAST       7'h7f
`define RCT_SQ_BIT           5
`define RCT_CORE_PERIOD_NS   5
`define RCT_STOP_WAIT_NS     100000

`endif

/* File: rtl/rct_pkg.sv */
// Purpose: shared types of the trim and flag block
// Assumes: rct_map.svh holds every figure
// Notes:   types only
`include "rct_map.svh"
package rct_pkg;
   typedef logic [7:0]                  rct_byte_type;
   typedef logic [`RCT_ADDR_WIDTH-1:0]  rct_addr_type;
   typedef logic [4:0]                  rct_mag_type;
   // calibration engine states inside one active second
   typedef enum logic [1:0] {CAL_IDLE, CAL_BLANK, CAL_DONE} rct_cal_state_type;
endpackage : rct_pkg

/* File: rtl/rct_cfg_if.sv */
// Purpose: carrier between the core-clock register side and the oscillator-clock engine
// Assumes: every signal crosses clock domains; receivers synchronise
// Notes:   no clocking block
`timescale 1ns/1ps
interface rct_cfg_if;
   import rct_pkg::*;
   logic         div_reset_tgl;   // toggles once per divider reset request
   logic         sign;            // positive trim when high
   logic         osc_disable;     // oscillator held when high
   rct_mag_type  magnitude;       // trim magnitude
   logic         heartbeat;       // toggles every running oscillator cycle
   logic         square;          // 512 Hz square wave

   modport core (output div_reset_tgl, output sign, output osc_disable, output magnitude,
                 input heartbeat, input square);
   modport osc  (input div_reset_tgl, input sign, input osc_disable, input magnitude,
                 output heartbeat, output square);
endinterface : rct_cfg_if

/* File: rtl/rct_osc_engine.sv */
// Purpose: divider chain and digital calibration on the oscillator clock
// Assumes: osc_clk is the oscillator; control levels are quasi-static
// Notes:   magnitude bits are synchronised as a bus; a change mid-flight may tear for one cycle
`timescale 1ns/1ps
`include "rct_map.svh"
module rct_osc_engine
   import rct_pkg::*;
(
   // clock and reset
   input  wire logic  osc_clk,
   input  wire logic  nrst,
   // carrier
   rct_cfg_if.osc     cfg
);
   // ***************************************************************
   // synchronisers
   // ***************************************************************
   logic [7:0]  sync1;
   logic [7:0]  sync2;
   logic        tgl_seen;
   wire  [7:0]  cfg_raw = {cfg.div_reset_tgl, cfg.osc_disable, cfg.sign, cfg.magnitude};

   // two flops per bit before any logic
   always_ff @(posedge osc_clk or negedge nrst) begin
      if (!nrst) begin
         sync1    <= 8'h00;
         sync2    <= 8'h00;
         tgl_seen <= 1'b0;
      end else begin
         sync1    <= cfg_raw;
         sync2    <= sync1;
         tgl_seen <= sync2[7];
      end
   end

   wire         div_reset = sync2[7] ^ tgl_seen;
   wire         halted    = sync2[6];
   wire         pos_trim  = sync2[5];
   wire [5:0]   cal_span  = {sync2[4:0], 1'b0};

   // ***************************************************************
   // divider chain and calibration
   // ***************************************************************
   logic [7:0]         lo;
   logic [6:0]         hi;
   logic [5:0]         sec;
   logic [5:0]         minute;
   logic [5:0]         free_cnt;
   logic [6:0]         blank_cnt;
   logic               beat;
   rct_cal_state_type  state;
   rct_cal_state_type  next_state;

   // one second per minute, first 2N minutes, never past the 62nd
   wire active   = (sec == 6'h00) && (minute < cal_span) && (minute < `RCT_CAL_MINUTES); // [R16] [R18] [R23]
   wire blanking = (state == CAL_BLANK);                                                // [R17]
   wire insert   = (state == CAL_IDLE) && active && pos_trim;                           // [R4] [R17]
   wire lo_wrap  = !blanking && (lo == `RCT_LO_LAST);                                   // [R15]
   wire [7:0] hi_sum = {1'b0, hi} + {7'h00, lo_wrap} + {7'h00, insert};                 // [R15]
   wire sec_tick = hi_sum[7];
   wire sec_wrap = sec_tick && (sec == `RCT_SEC_LAST);

   // calibration sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         CAL_IDLE:  if (active) next_state = pos_trim ? CAL_DONE : CAL_BLANK;
         CAL_BLANK: if (blank_cnt == `RCT_BLANK_LAST) next_state = CAL_DONE; // [R17]
         CAL_DONE:  if (sec != 6'h00) next_state = CAL_IDLE;
         default:   next_state = CAL_IDLE; // unused fourth code recovers to idle
      endcase
   end

   // a stopped oscillator holds everything; a control write clears the sub-second chain
   always_ff @(posedge osc_clk or negedge nrst) begin
      if (!nrst) begin
         lo <= 8'h00; hi <= 7'h00; sec <= 6'h00; minute <= 6'h00;
         free_cnt <= 6'h00; blank_cnt <= 7'h00; beat <= 1'b0; state <= CAL_IDLE;
      end else if (!halted) begin
         beat     <= !beat;
         state    <= next_state;
         if (div_reset) begin // [R20]
            lo       <= 8'h00;
            hi       <= 7'h00;
            free_cnt <= 6'h00;
         end else begin
            lo       <= blanking ? lo : lo + 8'h01;
            hi       <= hi_sum[6:0];
            free_cnt <= free_cnt + 6'h01; // untouched by trim [R19]
         end
         blank_cnt <= blanking ? blank_cnt + 7'h01 : 7'h00;
         if (sec_tick) sec <= sec_wrap ? 6'h00 : sec + 6'h01;
         if (sec_wrap) minute <= minute + 6'h01; // 64-minute cycle wraps [R16]
      end
   end

   assign cfg.heartbeat = beat;
   assign cfg.square    = free_cnt[`RCT_SQ_BIT]; // 64-cycle period, 512 Hz [R3]

   // ***************************************************************
   // checks
   // ***************************************************************
   blank_holds_a: assert property (@(posedge osc_clk) disable iff (!nrst)
      (blanking && !halted && !div_reset) |=> (lo == $past(lo))) // [R17]
      else $error("divider advanced while blanking");
   insert_once_a: assert property (@(posedge osc_clk) disable iff (!nrst)
      (insert && !halted) |=> (state == CAL_DONE)) // [R17]
      else $error("insertion not followed by done");
   no_cal_late_a: assert property (@(posedge osc_clk) disable iff (!nrst)
      (state == CAL_IDLE && minute >= cal_span) |=> (state != CAL_BLANK)) // [R18]
      else $error("calibration outside the trimmed minutes");
endmodule : rct_osc_engine

/* File: dv/rct_host_model.sv */
// Purpose: register-port master standing in for the serial front end
// Assumes: strobes are taken on rising core_clk, one per cycle
// Notes:   read data is taken one cycle after the read edge
`timescale 1ns/1ps
module rct_host_model
   import rct_pkg::*;
(
   // clock
   input  wire logic          core_clk,
   // strobes to the block
   output logic               reg_ptr_wr,
   output logic               reg_data_wr,
   output logic               reg_data_rd,
   output rct_byte_type       reg_wdata,
   // answer from the block
   input  wire rct_byte_type  reg_rdata
);
   // idle values at time zero
   initial begin
      reg_ptr_wr  = 1'b0;
      reg_data_wr = 1'b0;
      reg_data_rd = 1'b0;
      reg_wdata   = 8'h00;
   end

   // pointer load, then one data write or read; data bus inverted when idle so stale bytes never match
   task automatic access(input rct_addr_type a, input bit wr, input rct_byte_type d, output rct_byte_type q);
      @(posedge core_clk);
      reg_ptr_wr  <= 1'b1;
      reg_wdata   <= {4'h0, a};
      @(posedge core_clk);
      reg_ptr_wr  <= 1'b0;
      reg_data_wr <= wr;
      reg_data_rd <= !wr;
      reg_wdata   <= d;
      @(posedge core_clk);
      reg_data_wr <= 1'b0;
      reg_data_rd <= 1'b0;
      reg_wdata   <= ~d;
      @(posedge core_clk);
      q = reg_rdata;
   endtask : access
endmodule : rct_host_model

/* File: dv/rct_tb_top.sv */
// Purpose: self-checking bench for the trim, charge and halt-flag registers
// Assumes: osc_clk stands in for the oscillator at 12 ns and can be stopped
// Notes:   the whole run lies inside second 0 of minute 0, a calibration second; only the pin frequency is checked
`timescale 1ns/1ps
module rtc_control_trim_flags_tb_top
   import rct_pkg::*;
;
   logic core_clk, nrst, osc_clk, osc_go, pwr, dwr, drd;
   logic pin, c_en, c_di, run;
   logic [1:0] c_res;
   rct_byte_type wd, rd, q, d;
   rct_addr_type ptr;
   int miscompares, samples_checked, cnt;

   // clocks: core 5 ns, oscillator 12 ns and gateable
   initial begin
      core_clk = 1'b0;
      osc_clk = 1'b0;
      osc_go = 1'b1;
      nrst = 1'b0;
   end
   always #2.5 core_clk = ~core_clk;
   always #6 osc_clk = osc_go ? ~osc_clk : osc_clk;

   rct_host_model u_rct_host_model (.core_clk(core_clk), .reg_ptr_wr(pwr), .reg_data_wr(dwr),
      .reg_data_rd(drd), .reg_wdata(wd), .reg_rdata(rd));
   rct_top #(.STOP_CYCLES(50)) u_rct_top (.core_clk(core_clk), .nrst(nrst), .osc_clk(osc_clk),
      .reg_ptr_wr(pwr), .reg_data_wr(dwr), .reg_data_rd(drd), .reg_wdata(wd), .reg_rdata(rd),
      .reg_ptr(ptr), .pin_test_drive(pin), .charge_enable(c_en), .charge_diode(c_di),
      .charge_res(c_res), .osc_running(run));

   // expected charge path outputs packed as {enable, diode, res}
   function automatic logic [7:0] exp_charge(input rct_byte_type v);
      logic en;
      en = v[7:4] == 4'ha && (v[3:2] == 2'b01 || v[3:2] == 2'b10) && v[1:0] != 2'b00;
      return {4'h0, en, en && v[3:2] == 2'b10, en ? v[1:0] : 2'b00};
   endfunction : exp_charge

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // every access also checks where the pointer went afterwards
   task automatic rw(input rct_addr_type a, input bit wr, input rct_byte_type v);
      u_rct_host_model.access(a, wr, v, q);
      check({4'h0, ptr}, (a == 4'h7 || a == 4'h9) ? 8'h00 : {4'h0, a + 4'h1});
   endtask : rw

   task automatic complete_run;
      $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // watchdog well beyond the roughly 27 us of planned traffic
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      void'($urandom(21704));
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      check({7'h0, pin}, 8'h01);
      rw(4'h7, 0, 0); check(q, 8'h80);
      rw(4'h8, 0, 0); check(q, 8'h00);
      check({4'h0, c_en, c_di, c_res}, 8'h00);
      rw(4'h9, 0, 0); check(q, 8'h80);
      rw(4'hc, 1, 8'hff); rw(4'hc, 0, 0); check(q, 8'h00);
      // flag: write one keeps, write zero clears, low bits ignored
      rw(4'h9, 1, 8'hff); rw(4'h9, 0, 0); check(q, 8'h80);
      rw(4'h9, 1, 8'h7f); rw(4'h9, 0, 0); check(q, 8'h00);
      rw(4'h9, 1, 8'hff); rw(4'h9, 0, 0); check(q, 8'h00);
      // charge decode: keyed corner cases, two wrong keys, then random bytes
      for (int i = 0; i < 30; i++) begin
         d = (i < 8) ? 8'ha0 | i[1:0] | {i[3:2], 2'b00} : (i < 10 ? {4'h5 ^ i[3:0], 4'h5} : 8'($urandom));
         rw(4'h8, 1, d);
         repeat (3) @(posedge core_clk);
         check({4'h0, c_en, c_di, c_res}, exp_charge(d));
         rw(4'h8, 0, 0); check(q, d);
      end
      // static pin level follows the output bit, any trim value is held
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom) & 8'hbf;
         rw(4'h7, 1, d);
         repeat (3) @(posedge core_clk);
         check({7'h0, pin}, {7'h0, d[7]});
         rw(4'h7, 0, 0); check(q, d);
      end
      // square wave: one toggle every 32 oscillator cycles whatever the trim
      for (int i = 0; i < 3; i++) begin
         rw(4'h7, 1, i == 0 ? 8'h40 : (i == 1 ? 8'h7f : 8'h5f));
         repeat (40) @(posedge core_clk);
         cnt = 0;
         d[0] = pin;
         repeat (1536) begin
            @(posedge core_clk);
            cnt += (pin !== d[0]);
            d[0] = pin;
         end
         check({7'h0, cnt >= 19 && cnt <= 21}, 8'h01);
      end
      // halt flag: oscillator disable, then a real stop of the oscillator clock
      rw(4'h0, 1, 8'h80);
      repeat (4) @(posedge core_clk);
      check({7'h0, run}, 8'h00);
      rw(4'h9, 0, 0); check(q, 8'h80);
      rw(4'h0, 1, 8'h00);
      repeat (20) @(posedge core_clk);
      rw(4'h9, 1, 8'h00); rw(4'h9, 0, 0); check(q, 8'h00);
      check({7'h0, run}, 8'h01);
      osc_go = 1'b0;
      repeat (100) @(posedge core_clk);
      check({7'h0, run}, 8'h00);
      rw(4'h9, 0, 0); check(q, 8'h80);
      osc_go = 1'b1;
      complete_run();
   end
endmodule : rtc_control_trim_flags_tb_top
